// [logic/adcsp_pkg.sv]
// package: constants, carriers and states of the converter serial output port
package adcsp_pkg;
	// word shape
	localparam int unsigned ADCSP_WORD_BITS  = 16;
	localparam int unsigned ADCSP_BIT_W      = 5;
	localparam int unsigned ADCSP_CNT_W      = 4;
	// timing in master clock cycles (REF_CLK is the master clock)
	localparam logic [3:0]  ADCSP_READY_LEAD = 4'h2; // msb out before ready falls
	localparam logic [3:0]  ADCSP_SRC_LEAD   = 4'h8; // select fall to first clock rise
	localparam logic [3:0]  ADCSP_SRC_TAIL   = 4'h8; // last clock rise to ready high
	localparam logic [4:0]  ADCSP_LAST_BIT   = 5'h10;
	localparam logic [3:0]  ADCSP_CNT_ONE    = 4'h1;
	localparam logic [4:0]  ADCSP_BIT_ONE    = 5'h01;

	// finished conversion from the engine, same clock domain
	typedef struct packed {
		logic                       early; // pulse, result two cycles ahead of ready
		logic [ADCSP_WORD_BITS-1:0] word;
	} adcsp_word_t;

	// serial pins toward the host, each with its enable
	typedef struct packed {
		logic sclk;
		logic sclk_oe;
		logic serial_out;
		logic serial_out_oe;
	} adcsp_pin_t;

	typedef enum logic [2:0] {
		ADCSP_IDLE,
		ADCSP_ARM,
		ADCSP_WAIT,
		ADCSP_LEAD,
		ADCSP_SHIFT,
		ADCSP_TAIL,
		ADCSP_SINK
	} adcsp_state_t;
endpackage : adcsp_pkg

// [logic/adcsp_port.sv]
// module: serial output port of a 16-bit converter, clock sourcing or sinking
// How it works
// - mode pin high: port drives its own serial clock while shifting the word out
// - mode pin low: host supplies the serial clock, port shifts on it
// - sourcing mode, select high: serial clock and data pins float
// - sinking mode: data driven only while select low, floating while high
// - sourcing with select low: msb shows two cycles before ready falls
// - sourcing: ready returns high eight cycles after the last clock rise
// - sourcing: first clock rise eight cycles after select falls
// - sinking: host samples on rise; port moves to next bit after it
// - sinking: ready high right after the falling edge ending the word
// - end of conversion loads the port register and drives ready low
// - ready high after all bits out, or two cycles before next conversion end
`timescale 1ns/1ps
module adcsp_port
	import adcsp_pkg::*;
(
	// master clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RESET,
	// conversion engine
	input  wire adcsp_word_t RESULT,
	// host pins
	input  wire logic        PORT_MODE_PIN,
	input  wire logic        SELECT_N,
	input  wire logic        SCLK_IN,
	output logic             READY_N,
	output adcsp_pin_t       PINS
);
	// synchronisers for pins from the host side
	logic       mode_s1, mode_s2;
	logic       sel_s1, sel_n_s;
	logic       ck_s1, ck_s2, ck_s3;
	logic       sclk_rise, sclk_fall;
	logic       src_mode;

	// port state
	adcsp_state_t                state, next_state;
	logic [ADCSP_CNT_W-1:0]      cnt, next_cnt;
	logic [ADCSP_BIT_W-1:0]      bits, next_bits;
	logic [ADCSP_WORD_BITS-1:0]  shift, next_shift;
	logic [ADCSP_WORD_BITS-1:0]  word, next_word;
	logic                        ready_n, next_ready_n;
	logic                        sclk, next_sclk;

	// two flops on every host pin; ck_s3 only delays ck_s2 for edge finding
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			mode_s1 <= 1'b1;
			mode_s2 <= 1'b1;
			sel_s1  <= 1'b1;
			sel_n_s <= 1'b1;
			ck_s1   <= 1'b0;
			ck_s2   <= 1'b0;
			ck_s3   <= 1'b0;
		end else begin
			mode_s1 <= PORT_MODE_PIN;
			mode_s2 <= mode_s1;
			sel_s1  <= SELECT_N;
			sel_n_s <= sel_s1;
			ck_s1   <= SCLK_IN;
			ck_s2   <= ck_s1;
			ck_s3   <= ck_s2;
		end
	end

	assign src_mode  = mode_s2;          // high rail picks sourcing
	assign sclk_rise = ck_s2 & ~ck_s3;
	assign sclk_fall = ~ck_s2 & ck_s3;

	// next-state logic for the whole transfer
	always_comb begin
		next_state   = state;
		next_cnt     = cnt;
		next_bits    = bits;
		next_shift   = shift;
		next_word    = word;
		next_ready_n = ready_n;
		next_sclk    = sclk;
		if (RESULT.early) begin
			// new result wins over any transfer; unread word is dropped
			next_word    = RESULT.word;
			next_shift   = RESULT.word;      // msb on the pin now
			next_ready_n = 1'b1;
			next_cnt     = ADCSP_READY_LEAD - ADCSP_CNT_ONE;
			next_sclk    = 1'b0;
			next_bits    = '0;
			next_state   = ADCSP_ARM;
		end else begin
			case (state)
				ADCSP_ARM: begin
					if (cnt == '0) begin
						next_ready_n = 1'b0;     // word available
						next_state   = ADCSP_WAIT;
					end else begin
						next_cnt = cnt - ADCSP_CNT_ONE;
					end
				end
				ADCSP_WAIT: begin
					// in sinking mode the host raised select over ready fall
					if (!sel_n_s) begin
						next_bits  = '0;
						next_cnt   = ADCSP_SRC_LEAD - ADCSP_CNT_ONE;
						next_state = src_mode ? ADCSP_LEAD : ADCSP_SINK;
					end
				end
				ADCSP_LEAD: begin
					if (sel_n_s) begin
						next_state = ADCSP_WAIT;
					end else if (cnt == '0) begin
						next_sclk  = 1'b1;       // first rise
						next_bits  = ADCSP_BIT_ONE;
						next_state = ADCSP_SHIFT;
					end else begin
						next_cnt = cnt - ADCSP_CNT_ONE;
					end
				end
				ADCSP_SHIFT: begin
					if (sel_n_s) begin
						// aborted read restarts from the msb on the next select
						next_sclk  = 1'b0;
						next_shift = word;
						next_state = ADCSP_WAIT;
					end else if (sclk) begin
						next_sclk = 1'b0;        // half master rate
						if (bits == ADCSP_LAST_BIT) begin
							next_cnt   = ADCSP_SRC_TAIL - ADCSP_CNT_ONE - ADCSP_CNT_ONE;
							next_state = ADCSP_TAIL;
						end else begin
							next_shift = {shift[ADCSP_WORD_BITS-2:0], 1'b0};
						end
					end else begin
						next_sclk = 1'b1;
						next_bits = bits + ADCSP_BIT_ONE;
					end
				end
				ADCSP_TAIL: begin
					if (cnt == '0) begin
						next_ready_n = 1'b1;
						next_state   = ADCSP_IDLE;
					end else begin
						next_cnt = cnt - ADCSP_CNT_ONE;
					end
				end
				ADCSP_SINK: begin
					if (sel_n_s && bits == '0) begin
						next_state = ADCSP_WAIT;
					end else if (sclk_rise && bits != ADCSP_LAST_BIT) begin
						// move on only after the host has sampled
						next_bits = bits + ADCSP_BIT_ONE;
						if (bits != ADCSP_LAST_BIT - ADCSP_BIT_ONE)
							next_shift = {shift[ADCSP_WORD_BITS-2:0], 1'b0};
					end else if (sclk_fall && bits == ADCSP_LAST_BIT) begin
						next_ready_n = 1'b1;
						next_state   = ADCSP_IDLE;
					end
				end
				default: begin
					next_state = ADCSP_IDLE;
				end
			endcase
		end
	end

	// register the transfer state
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			state   <= ADCSP_IDLE;
			cnt     <= '0;
			bits    <= '0;
			shift   <= '0;
			word    <= '0;
			ready_n <= 1'b1;
			sclk    <= 1'b0;
		end else begin
			state   <= next_state;
			cnt     <= next_cnt;
			bits    <= next_bits;
			shift   <= next_shift;
			word    <= next_word;
			ready_n <= next_ready_n;
			sclk    <= next_sclk;
		end
	end

	// pins: enables follow the synced select, so they lag the pin by two cycles
	assign READY_N            = ready_n;
	assign PINS.sclk          = sclk;
	assign PINS.serial_out    = shift[ADCSP_WORD_BITS-1];
	assign PINS.sclk_oe       = src_mode & ~sel_n_s;
	assign PINS.serial_out_oe = ~sel_n_s;

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RESET);

	// ready is registered twice after the pulse edge, so it reads low on the third edge
	AST_READY_FALL: assert property (RESULT.early |=> ready_n [*2] ##1 !ready_n)
		else $error("ready did not fall two cycles after a new result");
	AST_MSB_FIRST: assert property (
		RESULT.early |=> (PINS.serial_out == $past(RESULT.word[ADCSP_WORD_BITS-1])) ##2 !ready_n)
		else $error("msb not on the pin ahead of ready fall");
	AST_SRC_FLOAT: assert property (
		src_mode && sel_n_s |-> !PINS.sclk_oe && !PINS.serial_out_oe)
		else $error("sourcing pins driven while select high");
	AST_SINK_DRIVE: assert property (
		!src_mode |-> (PINS.serial_out_oe == !sel_n_s) && !PINS.sclk_oe)
		else $error("sinking data enable does not follow select");
	AST_SRC_TAIL: assert property (
		state == ADCSP_SHIFT && sclk && bits == ADCSP_LAST_BIT && !sel_n_s && !RESULT.early
		|-> (!ready_n && !RESULT.early) [*8] ##1 ready_n)
		else $error("ready not high eight cycles after last clock rise");
	AST_SRC_LEAD: assert property (
		state == ADCSP_WAIT && src_mode && !sel_n_s && !RESULT.early
		|=> (!sclk && !sel_n_s && !RESULT.early) [*8] ##1 sclk)
		else $error("first clock rise not eight cycles after select");
	AST_HALF_RATE: assert property (
		state == ADCSP_SHIFT && $past(state) == ADCSP_SHIFT |-> sclk != $past(sclk))
		else $error("sourced clock not at half master rate");
	AST_SINK_HOLD: assert property (
		state == ADCSP_SINK && !sclk_rise && !RESULT.early |=> shift == $past(shift))
		else $error("data changed without a clock rise");
	AST_SINK_DONE: assert property (
		state == ADCSP_SINK && bits == ADCSP_LAST_BIT && sclk_fall && !RESULT.early
		|=> ready_n && state == ADCSP_IDLE)
		else $error("ready not high after the closing falling edge");
endmodule : adcsp_port

// [tb/adcsp_host.sv]
// host model: reads each word over the serial pins in either port mode
`timescale 1ns/1ps
module adcsp_host
	import adcsp_pkg::*;
(
	// clock, mode and enable
	input  wire logic       clk,
	input  wire logic       mode,
	input  wire logic       go,
	// device pins
	input  wire logic       ready_n,
	input  wire adcsp_pin_t pins,
	output logic            select_n,
	output logic            sclk_in,
	output logic [15:0]     word
);
	logic serial_out_w;
	logic sclk_w;
	// floating pins settle low through pull-downs
	assign serial_out_w = pins.serial_out_oe ? pins.serial_out : 1'b0;
	assign sclk_w       = pins.sclk_oe ? pins.sclk : 1'b0;
	// one read per ready fall; serial clock still outside frames
	initial begin
		select_n = 1'b1;
		sclk_in  = 1'b0;
		word     = 16'h0000;
		forever begin
			@(negedge ready_n); // select held high across the fall
			if (go) begin
				repeat (3) @(negedge clk);
				select_n = 1'b0;
				for (int i = 0; i < 16; i++) begin
					if (mode) @(posedge sclk_w);
					else begin
						repeat (4) @(negedge clk);
						sclk_in = 1'b1; // host clock in sinking mode
					end
					word = {word[14:0], serial_out_w}; // sampled on the rise
					if (!mode) repeat (4) @(negedge clk);
					if (!mode) sclk_in = 1'b0;
				end
				@(posedge ready_n);
				@(negedge clk);
				select_n = 1'b1;
			end
		end
	end
endmodule : adcsp_host

// [tb/tb_top.sv]
// testbench: conversion words read by the host model in both port modes
`timescale 1ns/1ps
module tb_top
	import adcsp_pkg::*;
;
	typedef struct {logic mode; logic [15:0] word;} adcsp_row_t;
	logic        REF_CLK       = 1'b0;
	logic        RESET         = 1'b1;
	adcsp_word_t RESULT        = '0;
	logic        PORT_MODE_PIN = 1'b1;
	logic        go            = 1'b1;
	logic        SELECT_N;
	logic        SCLK_IN;
	logic        READY_N;
	adcsp_pin_t  PINS;
	logic [15:0] word;
	int          err_total   = 0;
	int          comparisons = 0;
	adcsp_row_t  rows [4] = '{'{1'b1, 16'h8001}, '{1'b1, 16'h5a3c},
		'{1'b0, 16'h8001}, '{1'b0, 16'hc3a5}};

	always #10 REF_CLK = ~REF_CLK;

	adcsp_port dut_u (.REF_CLK(REF_CLK), .RESET(RESET), .RESULT(RESULT),
		.PORT_MODE_PIN(PORT_MODE_PIN), .SELECT_N(SELECT_N), .SCLK_IN(SCLK_IN),
		.READY_N(READY_N), .PINS(PINS));
	adcsp_host host_u (.clk(REF_CLK), .mode(PORT_MODE_PIN), .go(go), .ready_n(READY_N),
		.pins(PINS), .select_n(SELECT_N), .sclk_in(SCLK_IN), .word(word));

	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : final_report

	// one-cycle result pulse; returns just after the taking edge
	task automatic convert(logic [15:0] w);
		@(negedge REF_CLK);
		RESULT = '{early: 1'b1, word: w};
		@(negedge REF_CLK);
		RESULT.early = 1'b0;
	endtask : convert

	// bounded wait for the word to be emptied
	task automatic wait_ready();
		int n;
		n = 0;
		while (READY_N !== 1'b1 && n < 400) begin
			@(negedge REF_CLK);
			n++;
		end
		check("ready_return", {15'h0000, n == 400}, 16'h0000);
		repeat (6) @(negedge REF_CLK);
	endtask : wait_ready

	// watchdog: about seventeen times the expected run
	initial begin
		#200000;
		err_total++;
		final_report();
	end

	initial begin
		repeat (2) @(negedge REF_CLK);
		RESET = 1'b0;
		check("reset_ready", {15'h0000, READY_N}, 16'h0001);
		check("reset_oe", {14'h0000, PINS.sclk_oe, PINS.serial_out_oe}, 16'h0000);
		$display("test reset done");
		// ordinary reads, both modes
		foreach (rows[i]) begin
			PORT_MODE_PIN = rows[i].mode;
			repeat (6) @(negedge REF_CLK);
			convert(rows[i].word);
			check("msb_lead", {15'h0000, PINS.serial_out}, {15'h0000, rows[i].word[15]});
			check("ready_c1", {15'h0000, READY_N}, 16'h0001);
			@(negedge REF_CLK);
			@(negedge REF_CLK);
			check("ready_fall", {15'h0000, READY_N}, 16'h0000);
			wait_ready();
			check("word", word, rows[i].word);
			$display("test row %0d done", i);
		end
		// unread word left standing, then overwritten
		PORT_MODE_PIN = 1'b1;
		go = 1'b0;
		convert(16'h1234);
		repeat (60) @(negedge REF_CLK);
		check("idle_oe", {14'h0000, PINS.sclk_oe, PINS.serial_out_oe}, 16'h0000);
		check("unread_ready", {15'h0000, READY_N}, 16'h0000);
		go = 1'b1;
		convert(16'hfedc);
		check("overwrite_ready", {15'h0000, READY_N}, 16'h0001);
		// ready must stand high until the new word lands, or wait_ready returns at once
		@(negedge REF_CLK);
		check("overwrite_hold", {15'h0000, READY_N}, 16'h0001);
		@(negedge REF_CLK);
		check("overwrite_fall", {15'h0000, READY_N}, 16'h0000);
		wait_ready();
		check("overwrite_word", word, 16'hfedc);
		$display("test overwrite done");
		// reset in mid-run with an unread word standing
		go = 1'b0;
		convert(16'h0f0f);
		repeat (3) @(negedge REF_CLK);
		check("pre_reset_ready", {15'h0000, READY_N}, 16'h0000);
		RESET = 1'b1;
		repeat (2) @(negedge REF_CLK);
		RESET = 1'b0;
		check("rerst_ready", {15'h0000, READY_N}, 16'h0001);
		check("rerst_oe", {14'h0000, PINS.sclk_oe, PINS.serial_out_oe}, 16'h0000);
		repeat (2) @(negedge REF_CLK);
		check("rerst_idle", {15'h0000, READY_N}, 16'h0001);
		$display("test mid-run reset done");
		final_report();
	end
endmodule : tb_top
